// ==== bench/amep_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module amep_host (
   // clock
   input wire logic        clk,
   // requests
   output logic            s_axi_awvalid,
   output logic [7:0]      s_axi_awaddr,
   output logic            s_axi_wvalid,
   output logic [31:0]     s_axi_wdata,
   output logic            s_axi_bready,
   output logic            s_axi_arvalid,
   output logic [7:0]      s_axi_araddr,
   output logic            s_axi_rready,
   // answers
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp
);
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // each channel holds until its own handshake
   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      @(posedge clk);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {24'h000000, v};
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] idx, output logic [31:0] v,
                     output logic [1:0] resp);
      @(posedge clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : amep_host
`default_nettype wire

// ==== bench/amep_motion_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module amep_motion_asserts
   import amep_pkg::*;
#(
   parameter int DELAY_CYCLES = 4
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        ce,
   // detector side
   input wire logic        sample_valid,
   input wire logic [3:0]  motion_event,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   int since_rst;

   // timed events need a full tick
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         since_rst <= 0;
      else if (ce && since_rst <= DELAY_CYCLES)
         since_rst <= since_rst + 1;
   end

   ////////////////////////////////////////////////////////////////////////
   sequence both_taken;
      ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence resp_late;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence

   write_resp_a: assert property (both_taken |=> resp_late)
      else $error("write response timing");
   bresp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   write_refuse_a: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken in response");
   read_answer_a: assert property (
      ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   read_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during answer");
   event_pulse_a: assert property (
      |motion_event |=> (motion_event & $past(motion_event)) == 4'h0)
      else $error("event too long");
   slope_sample_a: assert property (
      motion_event[EV_ANY] |-> $past(sample_valid && ce, 2))
      else $error("slope event without sample");
   persist_min_a: assert property (
      motion_event[EV_HIGHG] || motion_event[EV_LOWG] |->
      since_rst >= DELAY_CYCLES)
      else $error("timed event too early");
endmodule : amep_motion_asserts

bind amep_motion amep_motion_asserts #(.DELAY_CYCLES(DELAY_CYCLES))
   u_chk (.*);
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
   import amep_pkg::*;
   ;
   localparam logic [7:0] RST [12] = '{8'h09, 8'h30, 8'h81, 8'h0F, 8'hC0,
      8'h00, 8'h14, 8'h14, 8'h00, 8'h00, 8'h00, 8'h00};
   logic        clk, arst_n, sample_valid, irq;
   logic [11:0] acc_x, acc_y, acc_z;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [3:0]  motion_event;
   int          error_cnt = 0;
   int          total_checks = 0;

   // short ticks: 4 cycles per 2 ms, 8 per second
   amep_motion #(.DELAY_CYCLES(4), .SECOND_CYCLES(8)) dut (
      .ce(1'b1), .s_axi_wstrb(4'h1), .*);
   amep_host host (.*);

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic rc(input logic [5:0] idx, input logic [7:0] exp);
      host.rd(idx, d, r);
      chk(d, {24'h000000, exp});
   endtask : rc

   task automatic smp(input logic [11:0] x, input logic [11:0] y);
      @(posedge clk);
      sample_valid <= 1'b1;
      acc_x        <= x;
      acc_y        <= y;
      acc_z        <= y;
      @(posedge clk);
      sample_valid <= 1'b0;
   endtask : smp

   task automatic ev(input logic [11:0] x, y, input int w, b,
                     input logic e);
      smp(x, y);
      repeat (w) @(posedge clk);
      host.rd(IDX_STATUS, d, r);
      chk(d[b], e);
   endtask : ev

   task automatic conclude();
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // about 700 cycles are needed
   initial begin
      #(20 * 3000);
      error_cnt++;
      conclude();
   end

   initial begin
      arst_n = 1'b0;
      sample_valid = 1'b0;
      {acc_x, acc_y, acc_z} = '0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 12; i++)
         rc(i < 8 ? 6'h22 + 6'(i) : 6'h28 + 6'(i), RST[i]);
      host.rd(6'h3F, d, r);
      chk(r, RESP_SLVERR);
      host.wr(IDX_LOWG_LEVEL, 8'hFF);
      rc(IDX_LOWG_LEVEL, 8'h7F);
      host.wr(IDX_LOWG_LEVEL, 8'h30);
      host.wr(IDX_ENABLE, 8'h0F);
      host.wr(IDX_DURATIONS, 8'h05);
      smp(12'h000, 12'h3E8);
      smp(12'h050, 12'h3E8);
      smp(12'h0A1, 12'h3E8);
      rc(IDX_STATUS, 8'h00);
      smp(12'h050, 12'h3E8);
      rc(IDX_STATUS, 8'h0C);
      chk(irq, 1'b1);
      host.wr(IDX_ENABLE, 8'h00);
      rc(IDX_STATUS, 8'h0C);
      chk(irq, 1'b0);
      host.wr(IDX_ENABLE, 8'h0F);
      host.wr(IDX_CLEAR, 8'h0F);
      rc(IDX_STATUS, 8'h00);
      chk(irq, 1'b0);
      // the axis sum stays above the band
      host.wr(IDX_HYST_MODE, 8'h85);
      ev(12'h0C8, 12'h0C8, 60, EV_LOWG, 1'b0);
      host.wr(IDX_HYST_MODE, 8'h81);
      host.wr(IDX_CTRL, 8'h01);
      ev(12'h0C8, 12'h0C8, 60, EV_LOWG, 1'b0);
      host.wr(IDX_CTRL, 8'h00);
      ev(12'h0C8, 12'h0C8, 20, EV_LOWG, 1'b0);
      ev(12'h0C8, 12'h0C8, 40, EV_LOWG, 1'b1);
      host.wr(IDX_CLEAR, 8'h0F);
      ev(12'h600, 12'h3E8, 80, EV_HIGHG, 1'b0);
      ev(12'h601, 12'h3E8, 30, EV_HIGHG, 1'b0);
      ev(12'h601, 12'h3E8, 50, EV_HIGHG, 1'b1);
      host.wr(IDX_DURATIONS, 8'h40);
      host.wr(IDX_CTRL, 8'h04);
      smp(12'h000, 12'h3E8);
      host.wr(IDX_CLEAR, 8'h0F);
      ev(12'h000, 12'h3E8, 100, EV_QUIET, 1'b0);
      ev(12'h000, 12'h3E8, 100, EV_QUIET, 1'b1);
      conclude();
   end
endmodule : tb
`default_nettype wire

// ==== hdl/amep_motion.sv ====
// Function
// - low-g level is the 8-bit level field times 7.81 mg, 0 to 1.992 g
// - low-g hysteresis is the 2-bit field times 125 mg in every range
// - low-g mode 0 checks each axis, mode 1 checks the axis sum
// - high-g hysteresis is field times 125/250/500/1000 mg by range
// - high-g must persist (delay field + 1) times 2 ms before event
// - high-g level is field times 7.81/15.63/31.25/62.5 mg by range
// - slow-motion fires after (quiet duration low two bits + 1) slopes above level
// - no-motion fires after quiet time in seconds from coded duration
// - any-motion fires after (slope duration + 1) slopes above level
// - any-motion level is field times 3.91/7.81/15.63/31.25 mg by range
// - reset gives high-g delay of 32 ms and low-g level of 375 mg
// - low-g must persist (low delay field + 1) times 2 ms before event
// - quiet-motion level is field times 3.91/7.81/15.63/31.25 mg by range
`timescale 1ns/1ps
`default_nettype none
module amep_motion
   import amep_pkg::*;
#(
   parameter int DELAY_CYCLES = DELAY_STEP_CYCLES,
   parameter int SECOND_CYCLES = QUIET_STEP_CYCLES
) (
   // clock, reset, enable
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              ce,
   // acceleration samples, two's complement
   input  wire logic              sample_valid,
   input  wire logic [11:0]       acc_x,
   input  wire logic [11:0]       acc_y,
   input  wire logic [11:0]       acc_z,
   // axi4-lite write address
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   // axi4-lite write data
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   // axi4-lite write response
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   // axi4-lite read address
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   // axi4-lite read data
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   // events and interrupt
   output logic [NUM_EV-1:0]      motion_event,
   output logic                   irq
);

   function automatic logic [12:0] mag13(input logic signed [12:0] v);
      mag13 = v[12] ? 13'(-v) : 13'(v);
   endfunction : mag13

   function automatic logic reg_mapped(input logic [5:0] idx);
      unique case (idx)
         IDX_LOWG_DELAY, IDX_LOWG_LEVEL, IDX_HYST_MODE, IDX_HIGHG_DELAY,
         IDX_HIGHG_LEVEL, IDX_DURATIONS, IDX_ANY_LEVEL, IDX_QUIET_LEVEL,
         IDX_CTRL, IDX_STATUS, IDX_ENABLE, IDX_CLEAR: reg_mapped = 1'b1;
         default: reg_mapped = 1'b0;
      endcase
   endfunction : reg_mapped

   ////////////////////////////////////////////////////////////////////////
   // register file
   logic [7:0]        lowg_delay;
   logic [7:0]        lowg_level_reg;
   logic [7:0]        hyst_mode;
   logic [7:0]        highg_delay;
   logic [7:0]        highg_level_reg;
   logic [7:0]        durations;
   logic [7:0]        any_level_reg;
   logic [7:0]        quiet_level_reg;
   logic [7:0]        ctrl;
   logic [NUM_EV-1:0] status;
   logic [NUM_EV-1:0] enable;

   logic              aw_held;
   logic              w_held;
   logic [5:0]        aw_idx;
   logic [7:0]        w_byte;
   logic              w_lane0;
   logic              wr_fire;
   logic              wr_en;
   logic [NUM_EV-1:0] clr;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
   assign wr_en         = wr_fire && w_lane0 && reg_mapped(aw_idx);
   assign clr           = (wr_en && aw_idx == IDX_CLEAR) ?
                          w_byte[NUM_EV-1:0] : '0;

   // address and data taken in either order
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_idx       <= '0;
         w_byte       <= '0;
         w_lane0      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx  <= s_axi_awaddr[7:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lowg_delay      <= RST_LOWG_DELAY;
         lowg_level_reg  <= RST_LOWG_LEVEL;
         hyst_mode       <= RST_HYST_MODE;
         highg_delay     <= RST_HIGHG_DELAY;
         highg_level_reg <= RST_HIGHG_LEVEL;
         durations       <= RST_DURATIONS;
         any_level_reg   <= RST_ANY_LEVEL;
         quiet_level_reg <= RST_QUIET_LEVEL;
         ctrl            <= RST_CTRL;
         enable          <= RST_EVENTS;
      end else if (ce && wr_en) begin
         unique case (aw_idx)
            IDX_LOWG_DELAY:  lowg_delay      <= w_byte;
            IDX_LOWG_LEVEL:  lowg_level_reg  <= w_byte;
            IDX_HYST_MODE:   hyst_mode       <= w_byte;
            IDX_HIGHG_DELAY: highg_delay     <= w_byte;
            IDX_HIGHG_LEVEL: highg_level_reg <= w_byte;
            IDX_DURATIONS:   durations       <= w_byte;
            IDX_ANY_LEVEL:   any_level_reg   <= w_byte;
            IDX_QUIET_LEVEL: quiet_level_reg <= w_byte;
            IDX_CTRL:        ctrl            <= w_byte & CTRL_MASK;
            IDX_ENABLE:      enable          <= w_byte[NUM_EV-1:0];
            default: ;
         endcase
      end
   end

   // low-g level bit 7 is write-only, reads zero
   function automatic logic [7:0] read_mux(input logic [5:0] idx);
      logic [7:0] lvl_rd;
      lvl_rd = lowg_level_reg;
      lvl_rd[LOWG_LEVEL_WO_BIT] = 1'b0;
      unique case (idx)
         IDX_LOWG_DELAY:  read_mux = lowg_delay;
         IDX_LOWG_LEVEL:  read_mux = lvl_rd;
         IDX_HYST_MODE:   read_mux = hyst_mode;
         IDX_HIGHG_DELAY: read_mux = highg_delay;
         IDX_HIGHG_LEVEL: read_mux = highg_level_reg;
         IDX_DURATIONS:   read_mux = durations;
         IDX_ANY_LEVEL:   read_mux = any_level_reg;
         IDX_QUIET_LEVEL: read_mux = quiet_level_reg;
         IDX_CTRL:        read_mux = ctrl;
         IDX_STATUS:      read_mux = 8'(status);
         IDX_ENABLE:      read_mux = 8'(enable);
         default:         read_mux = 8'h00;
      endcase
   endfunction : read_mux

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, read_mux(s_axi_araddr[7:2])};
            s_axi_rresp  <= reg_mapped(s_axi_araddr[7:2]) ?
                            RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // levels in sample lsb, from the current range
   amep_range_t range;
   logic [2:0]  rsh;
   logic [13:0] lo_lvl;
   logic [13:0] lo_hy;
   logic [13:0] hi_lvl;
   logic [13:0] hi_hy;
   logic [13:0] any_lvl;
   logic [13:0] quiet_lvl;
   logic        qsel;

   assign range = amep_range_t'(ctrl[CTRL_RANGE_LSB +: 2]);
   assign rsh   = {1'b0, range};
   assign qsel  = ctrl[CTRL_QSEL_BIT];
   // g-fixed quantities shrink in lsb as the range widens
   assign lo_lvl = {6'h00, lowg_level_reg} << (LOWG_LEVEL_SHIFT - rsh);
   assign lo_hy  = {12'h000, hyst_mode[LOWG_HYST_LSB +: 2]}
                   << (LOWG_HYST_SHIFT - rsh);
   // range-scaled quantities are fixed in lsb
   assign hi_lvl = {6'h00, highg_level_reg} << HIGHG_LEVEL_SHIFT;
   assign hi_hy  = {12'h000, hyst_mode[HIGHG_HYST_LSB +: 2]}
                   << HIGHG_HYST_SHIFT;
   assign any_lvl   = {6'h00, any_level_reg} << SLOPE_LEVEL_SHIFT;
   assign quiet_lvl = {6'h00, quiet_level_reg} << SLOPE_LEVEL_SHIFT;

   ////////////////////////////////////////////////////////////////////////
   // per-axis magnitude and slope
   logic [11:0] axis [3];
   logic [11:0] prev [3];
   logic [12:0] mag  [3];
   logic [12:0] dlt  [3];
   logic        have_prev;

   assign axis[0] = acc_x;
   assign axis[1] = acc_y;
   assign axis[2] = acc_z;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_axis
         assign mag[gi] = mag13({axis[gi][11], axis[gi]});
         assign dlt[gi] = mag13(13'({axis[gi][11], axis[gi]}
                          - {prev[gi][11], prev[gi]}));
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               prev[gi] <= 12'h000;
            end else if (ce && sample_valid) begin
               prev[gi] <= axis[gi];
            end
         end
      end
   endgenerate

   logic [13:0] mag_sum;
   logic [13:0] lo_band;
   logic [13:0] hi_band;
   logic        lo_active;
   logic        hi_active;
   logic        lo_hit;
   logic        hi_hit;
   logic        any_hit;
   logic        quiet_hit;

   assign mag_sum = 14'(mag[0]) + 14'(mag[1]) + 14'(mag[2]);
   // hysteresis widens the band while the condition holds
   assign lo_band = lo_active ? 14'(lo_lvl + lo_hy) : lo_lvl;
   assign hi_band = !hi_active ? hi_lvl :
                    (hi_lvl > hi_hy) ? 14'(hi_lvl - hi_hy) : 14'h0000;
   assign lo_hit  = hyst_mode[LOWG_MODE_BIT] ? (mag_sum < lo_band) :
                    ((14'(mag[0]) < lo_band) && (14'(mag[1]) < lo_band) &&
                     (14'(mag[2]) < lo_band));
   assign hi_hit  = (14'(mag[0]) > hi_band) || (14'(mag[1]) > hi_band) ||
                    (14'(mag[2]) > hi_band);
   assign any_hit = (14'(dlt[0]) > any_lvl) || (14'(dlt[1]) > any_lvl) ||
                    (14'(dlt[2]) > any_lvl);
   assign quiet_hit = (14'(dlt[0]) > quiet_lvl) ||
                      (14'(dlt[1]) > quiet_lvl) ||
                      (14'(dlt[2]) > quiet_lvl);

   // condition flags refreshed per sample
   logic still;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lo_active <= 1'b0;
         hi_active <= 1'b0;
         have_prev <= 1'b0;
         still     <= 1'b0;
      end else if (ce && sample_valid) begin
         lo_active <= lo_hit;
         hi_active <= hi_hit;
         have_prev <= 1'b1;
         still     <= have_prev && !quiet_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // slope counters saturate: one event per run
   logic [2:0] any_cnt;
   logic [2:0] slow_cnt;
   logic [2:0] any_need;
   logic [2:0] slow_need;
   logic       any_ev;
   logic       slow_ev;

   assign any_need  = {1'b0, durations[ANY_DUR_LSB +: 2]} + 3'd1;
   assign slow_need = {1'b0, durations[QUIET_DUR_LSB +: 2]} + 3'd1;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         any_cnt <= 3'd0;
         any_ev  <= 1'b0;
      end else if (ce) begin
         any_ev <= 1'b0;
         if (sample_valid && have_prev) begin
            if (!any_hit) begin
               any_cnt <= 3'd0;
            end else if (any_cnt != any_need) begin
               any_cnt <= any_cnt + 3'd1;
               any_ev  <= (any_cnt + 3'd1 == any_need);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         slow_cnt <= 3'd0;
         slow_ev  <= 1'b0;
      end else if (ce) begin
         slow_ev <= 1'b0;
         if (qsel) begin
            slow_cnt <= 3'd0;
         end else if (sample_valid && have_prev) begin
            if (!quiet_hit) begin
               slow_cnt <= 3'd0;
            end else if (slow_cnt != slow_need) begin
               slow_cnt <= slow_cnt + 3'd1;
               slow_ev  <= (slow_cnt + 3'd1 == slow_need);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // persistence timers
   logic [8:0] lo_target;
   logic [8:0] hi_target;
   logic [8:0] nomo_target;
   logic       lo_ev;
   logic       hi_ev;
   logic       nomo_ev;
   logic [5:0] qdur;

   assign lo_target = {1'b0, lowg_delay} + 9'h001;
   assign hi_target = {1'b0, highg_delay} + 9'h001;
   assign qdur      = durations[QUIET_DUR_LSB +: 6];
   assign nomo_target = qdur[5] ? ({1'b0, qdur[4:0], 3'b000}
                                   + QUIET_HIGH_BASE) :
                        qdur[4] ? ({3'b000, qdur[3:0], 2'b00}
                                   + QUIET_MID_BASE) :
                        ({5'h00, qdur[3:0]} + 9'h001);

   amep_persist #(.TICK_CYCLES(DELAY_CYCLES)) u_lowg_timer (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .cond   (lo_active),
      .target (lo_target),
      .fire   (lo_ev)
   );

   amep_persist #(.TICK_CYCLES(DELAY_CYCLES)) u_highg_timer (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .cond   (hi_active),
      .target (hi_target),
      .fire   (hi_ev)
   );

   amep_persist #(.TICK_CYCLES(SECOND_CYCLES)) u_nomo_timer (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .cond   (still && qsel),
      .target (nomo_target),
      .fire   (nomo_ev)
   );

   ////////////////////////////////////////////////////////////////////////
   // sticky status; an event beats a same-cycle clear
   logic [NUM_EV-1:0] ev;
   logic [NUM_EV-1:0] next_status;

   assign ev[EV_LOWG]  = lo_ev;
   assign ev[EV_HIGHG] = hi_ev;
   assign ev[EV_ANY]   = any_ev;
   assign ev[EV_QUIET] = slow_ev || nomo_ev;
   assign next_status  = (status & ~clr) | ev;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status       <= RST_EVENTS;
         irq          <= 1'b0;
         motion_event <= RST_EVENTS;
      end else if (ce) begin
         status       <= next_status;
         irq          <= |(next_status & enable);
         motion_event <= ev;
      end
   end

endmodule : amep_motion
`default_nettype wire

// ==== hdl/amep_persist.sv ====
`timescale 1ns/1ps
`default_nettype none
module amep_persist #(
   parameter int TICK_CYCLES = 100000
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       ce,
   // condition and duration in ticks
   input  wire logic       cond,
   input  wire logic [8:0] target,
   // pulse when cond held for target ticks
   output logic            fire
);
   localparam int PW = $clog2(TICK_CYCLES + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

   logic [PW-1:0] pre;
   logic [8:0]    ticks;
   logic          done;

   // a drop restarts the count: one fire per unbroken run
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre   <= '0;
         ticks <= '0;
         done  <= 1'b0;
         fire  <= 1'b0;
      end else if (ce) begin
         fire <= 1'b0;
         if (!cond) begin
            pre   <= '0;
            ticks <= '0;
            done  <= 1'b0;
         end else if (!done) begin
            if (pre == PRE_LAST) begin
               pre   <= '0;
               ticks <= ticks + 9'h001;
               if (ticks + 9'h001 == target) begin
                  fire <= 1'b1;
                  done <= 1'b1;
               end
            end else begin
               pre <= pre + PW'(1);
            end
         end
      end
   end
endmodule : amep_persist
`default_nettype wire

// ==== hdl/amep_pkg.sv ====
package amep_pkg;

   // time bases
   localparam int CLK_PERIOD_NS    = 20;
   localparam int DELAY_STEP_NS    = 2_000_000;
   localparam int QUIET_STEP_NS    = 1_000_000_000;
   localparam int DELAY_STEP_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;
   localparam int QUIET_STEP_CYCLES = QUIET_STEP_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////
   // register indices; byte address = 4 * index
   localparam int             ADDR_W           = 8;
   localparam logic [5:0]     IDX_LOWG_DELAY   = 6'h22;
   localparam logic [5:0]     IDX_LOWG_LEVEL   = 6'h23;
   localparam logic [5:0]     IDX_HYST_MODE    = 6'h24;
   localparam logic [5:0]     IDX_HIGHG_DELAY  = 6'h25;
   localparam logic [5:0]     IDX_HIGHG_LEVEL  = 6'h26;
   localparam logic [5:0]     IDX_DURATIONS    = 6'h27;
   localparam logic [5:0]     IDX_ANY_LEVEL    = 6'h28;
   localparam logic [5:0]     IDX_QUIET_LEVEL  = 6'h29;
   localparam logic [5:0]     IDX_CTRL         = 6'h30;
   localparam logic [5:0]     IDX_STATUS       = 6'h31;
   localparam logic [5:0]     IDX_ENABLE       = 6'h32;
   localparam logic [5:0]     IDX_CLEAR        = 6'h33;

   // reset values
   localparam logic [7:0]     RST_LOWG_DELAY   = 8'h09;
   localparam logic [7:0]     RST_LOWG_LEVEL   = 8'h30;
   localparam logic [7:0]     RST_HYST_MODE    = 8'h81;
   localparam logic [7:0]     RST_HIGHG_DELAY  = 8'h0F;
   localparam logic [7:0]     RST_HIGHG_LEVEL  = 8'hC0;
   localparam logic [7:0]     RST_DURATIONS    = 8'h00;
   localparam logic [7:0]     RST_ANY_LEVEL    = 8'h14;
   localparam logic [7:0]     RST_QUIET_LEVEL  = 8'h14;
   localparam logic [7:0]     RST_CTRL         = 8'h00;
   localparam logic [3:0]     RST_EVENTS       = 4'h0;

   // field positions
   localparam int             LOWG_LEVEL_WO_BIT = 7;
   localparam int             HIGHG_HYST_LSB   = 6;
   localparam int             LOWG_MODE_BIT    = 2;
   localparam int             LOWG_HYST_LSB    = 0;
   localparam int             QUIET_DUR_LSB    = 2;
   localparam int             ANY_DUR_LSB      = 0;
   localparam int             CTRL_RANGE_LSB   = 0;
   localparam int             CTRL_QSEL_BIT    = 2;
   localparam logic [7:0]     CTRL_MASK        = 8'h07;

   // event bits
   localparam int             EV_LOWG          = 0;
   localparam int             EV_HIGHG         = 1;
   localparam int             EV_ANY           = 2;
   localparam int             EV_QUIET         = 3;
   localparam int             NUM_EV           = 4;

   // sample lsb: 7.81/8 mg at 2 g, doubling per range
   localparam logic [2:0]     LOWG_LEVEL_SHIFT = 3'd3;
   localparam logic [2:0]     LOWG_HYST_SHIFT  = 3'd7;
   localparam logic [2:0]     HIGHG_LEVEL_SHIFT = 3'd3;
   localparam logic [2:0]     HIGHG_HYST_SHIFT = 3'd7;
   localparam logic [2:0]     SLOPE_LEVEL_SHIFT = 3'd2;

   // no-motion seconds coding
   localparam logic [8:0]     QUIET_MID_BASE   = 9'h014;
   localparam logic [8:0]     QUIET_HIGH_BASE  = 9'h058;

   localparam logic [1:0]     RESP_OKAY        = 2'b00;
   localparam logic [1:0]     RESP_SLVERR      = 2'b10;

   typedef enum logic [1:0] {
      AMEP_RANGE_2G  = 2'b00,
      AMEP_RANGE_4G  = 2'b01,
      AMEP_RANGE_8G  = 2'b10,
      AMEP_RANGE_16G = 2'b11
   } amep_range_t;

endpackage : amep_pkg
